// ===== pkg/ssp_pkg.sv
package ssp_pkg;
    // register map of the device, reached over the host's own port
    localparam logic [2:0] REG_IRQ_FLAGS = 3'h0;
    localparam logic [2:0] REG_IRQ_ENABLES = 3'h1;
    localparam logic [2:0] REG_IRQ_PRIORITY = 3'h2;
    localparam logic [2:0] REG_RX_STATUS = 3'h3;
    localparam logic [2:0] REG_TX_HOLD = 3'h4;
    localparam logic [2:0] REG_TX_STATUS = 3'h5;
    localparam logic [2:0] REG_BAUD = 3'h6;
    localparam logic [2:0] REG_RX_BUF = 3'h7;
    // flag and enable bit positions
    localparam int RX_FLAG_BIT = 5;
    localparam int TX_FLAG_BIT = 4;
    // receive status control fields
    localparam int RS_PORT_EN = 7;
    localparam int RS_RX9 = 6;
    localparam int RS_SINGLE = 5;
    localparam int RS_CONT = 4;
    localparam int RS_FRAME_ERR = 2;
    localparam int RS_OVERRUN = 1;
    localparam int RS_RECEIVE_NINTH_BIT = 0;
    // transmit status control fields
    localparam int TS_CLK_SRC = 7;
    localparam int TS_TX9 = 6;
    localparam int TS_TX_EN = 5;
    localparam int TS_SYNC = 4;
    localparam int TS_SHIFT_EMPTY = 1;
    localparam int TS_TRANSMIT_NINTH_BIT = 0;
    localparam logic [7:0] TS_RESET = 8'h02;
    // controller registers (axi word offsets)
    localparam logic [11:0] AX_CMD = 12'h000;
    localparam logic [11:0] AX_WDATA = 12'h004;
    localparam logic [11:0] AX_STATUS = 12'h008;
    localparam logic [11:0] AX_RDATA = 12'h00c;
    localparam logic [11:0] AX_LINK = 12'h010;
    // link clock half period in core cycles (320 ns / 40 ns / 2)
    localparam int CORE_NS = 40;
    localparam int LINK_PERIOD_NS = 320;
    localparam int HALF_CYC = LINK_PERIOD_NS / CORE_NS / 2;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ssp_pkg

// ===== pkg/ssp_if.sv
`timescale 1ns/1ns
interface ssp_if;
    // shift clock, driven by the master end
    logic sck;
    // data line: each end drives when its enable (active low) is low
    logic dat_dev_o;
    logic dat_dev_oe_n;
    logic dat_host_o;
    logic dat_host_oe_n;
    // sleep request from the host side
    logic sleep;
    // register port of the device
    logic reg_we;
    logic reg_re;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    // device wake interrupt
    logic wake_irq;
    wire dat = !dat_dev_oe_n ? dat_dev_o : (!dat_host_oe_n ? dat_host_o : 1'b1);
    modport dev (input sck, output dat_dev_o, output dat_dev_oe_n, input dat, input sleep,
                 input reg_we, input reg_re, input reg_addr, input reg_wdata, output reg_rdata, output wake_irq);
    modport host (output sck, output dat_host_o, output dat_host_oe_n, input dat, output sleep,
                  output reg_we, output reg_re, output reg_addr, output reg_wdata, input reg_rdata, input wake_irq);
endinterface : ssp_if

// ===== rtl/ssp_device.sv
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ns
module ssp_device (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link and register port
    ssp_if.dev bus
);
    // pin synchronisers; third stage only feeds the edge finder
    logic sck_s1_r;
    logic sck_s2_r;
    logic sck_s3_r;
    logic dat_s1_r;
    logic dat_s2_r;
    // register file
    logic [7:0] flags_r;
    logic [7:0] enables_r;
    logic [7:0] prio_r;
    logic [7:0] baud_r;
    logic [7:0] rs_r;
    logic [7:0] ts_r;
    // transmit path
    logic [7:0] tx_hold_r;
    logic tx_hold_full_r;
    logic hold_9_r;
    logic [8:0] tsr_r;
    logic tsr_busy_r;
    logic [3:0] tx_cnt_r;
    // receive path
    logic [8:0] rsr_r;
    logic [3:0] rx_cnt_r;
    logic [7:0] rx_buf_r;
    logic rx_full_r;
    // read port
    logic [7:0] rdata_r;

    // address compare shared by all strobes
    function automatic logic reg_hit(input logic [2:0] addr, input logic [2:0] sel);
        return addr == sel;
    endfunction : reg_hit

    // sleep is not read: the core keeps running, so low-power transfers need no special path
    wire sck_rise = sck_s2_r && !sck_s3_r;
    wire sck_fall = !sck_s2_r && sck_s3_r;
    wire port_on = rs_r[ssp_pkg::RS_PORT_EN] && ts_r[ssp_pkg::TS_SYNC] && !ts_r[ssp_pkg::TS_CLK_SRC];
    wire tx_on = port_on && ts_r[ssp_pkg::TS_TX_EN];
    wire rx_on = port_on && rs_r[ssp_pkg::RS_CONT] && !tsr_busy_r;
    wire [3:0] tx_bits = ts_r[ssp_pkg::TS_TX9] ? 4'h9 : 4'h8;
    wire [3:0] rx_bits = rs_r[ssp_pkg::RS_RX9] ? 4'h9 : 4'h8;
    // write strobes, one per writable register, and the receive buffer read strobe
    wire wr_hold = bus.reg_we && reg_hit(bus.reg_addr, ssp_pkg::REG_TX_HOLD);
    wire wr_rs = bus.reg_we && reg_hit(bus.reg_addr, ssp_pkg::REG_RX_STATUS);
    wire wr_ts = bus.reg_we && reg_hit(bus.reg_addr, ssp_pkg::REG_TX_STATUS);
    wire wr_en = bus.reg_we && reg_hit(bus.reg_addr, ssp_pkg::REG_IRQ_ENABLES);
    wire wr_prio = bus.reg_we && reg_hit(bus.reg_addr, ssp_pkg::REG_IRQ_PRIORITY);
    wire wr_baud = bus.reg_we && reg_hit(bus.reg_addr, ssp_pkg::REG_BAUD);
    wire rd_rx = bus.reg_re && reg_hit(bus.reg_addr, ssp_pkg::REG_RX_BUF);
    wire tx_last = tsr_busy_r && sck_rise && tx_cnt_r == tx_bits - 4'h1;
    // load at once, load held word after last bit
    wire tsr_load = tx_on && tx_hold_full_r && (!tsr_busy_r || tx_last);
    wire rx_done = rx_on && sck_fall && rx_cnt_r == rx_bits - 4'h1;
    wire [8:0] rx_word = {dat_s2_r, rsr_r[8:1]} >> (4'h9 - rx_bits);
    // an unread buffer is never overwritten; the late word counts as overrun
    wire rx_store = rx_done && !rx_full_r;
    wire rx_overrun = rx_done && rx_full_r;
    // writing continuous enable low clears both error bits
    wire err_clear = wr_rs && !bus.reg_wdata[ssp_pkg::RS_CONT];
    wire shift_empty = !tsr_busy_r && !tsr_load;
    wire [7:0] wake_src = flags_r & enables_r;

    always_ff @(posedge core_clk) begin
        sck_s1_r <= bus.sck;
        sck_s2_r <= sck_s1_r;
        sck_s3_r <= sck_s2_r;
        dat_s1_r <= bus.dat;
        dat_s2_r <= dat_s1_r;
    end

    // transmit as slave; lsb first on rising edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tsr_r <= 9'h1ff;
            tsr_busy_r <= 1'b0;
            tx_cnt_r <= 4'h0;
        end else if (tsr_load) begin
            // reload on the last rise keeps the line gapless
            // ninth bit goes with the word
            tsr_r <= {hold_9_r, tx_hold_r};
            tsr_busy_r <= 1'b1;
            tx_cnt_r <= 4'h0;
        end else if (tx_last) begin
            tsr_busy_r <= 1'b0;
        end else if (tsr_busy_r && sck_rise) begin
            tsr_r <= {1'b1, tsr_r[8:1]};
            tx_cnt_r <= tx_cnt_r + 4'h1;
        end
    end

    // write starts transmit; only a write clears the empty flag
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_hold_r <= 8'h00;
            hold_9_r <= 1'b0;
            tx_hold_full_r <= 1'b0;
        end else if (wr_hold) begin
            tx_hold_r <= bus.reg_wdata;
            hold_9_r <= ts_r[ssp_pkg::TS_TRANSMIT_NINTH_BIT];
            tx_hold_full_r <= 1'b1;
        end else if (tsr_load) begin
            // held word waits while shifter busy
            tx_hold_full_r <= 1'b0;
        end
    end

    // continuous receive runs regardless of sleep
    always_ff @(posedge core_clk) begin
        if (!rst_n || !rx_on) begin
            rsr_r <= 9'h000;
            rx_cnt_r <= 4'h0;
        end else if (rx_done) begin
            rx_cnt_r <= 4'h0;
        end else if (sck_fall) begin
            rsr_r <= {dat_s2_r, rsr_r[8:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_buf_r <= 8'h00;
            rx_full_r <= 1'b0;
        end else if (rx_store) begin
            rx_buf_r <= rx_word[7:0];
            rx_full_r <= 1'b1;
        end else if (rd_rx) begin
            rx_full_r <= 1'b0;
        end
    end

    // control registers; clearing continuous enable clears errors
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rs_r <= 8'h00;
            ts_r <= ssp_pkg::TS_RESET;
            enables_r <= 8'h00;
            prio_r <= 8'h00;
            baud_r <= 8'h00;
        end else begin
            if (wr_rs) begin
                rs_r[7:3] <= bus.reg_wdata[7:3];
                if (err_clear) begin
                    rs_r[ssp_pkg::RS_OVERRUN] <= 1'b0;
                    rs_r[ssp_pkg::RS_FRAME_ERR] <= 1'b0;
                end
            end
            // set wins over a clear in the same cycle
            if (rx_overrun) begin
                rs_r[ssp_pkg::RS_OVERRUN] <= 1'b1;
            end
            if (rx_store) begin
                rs_r[ssp_pkg::RS_RECEIVE_NINTH_BIT] <= rx_word[8];
            end
            if (wr_ts) begin
                ts_r[7:4] <= bus.reg_wdata[7:4];
                ts_r[ssp_pkg::TS_TRANSMIT_NINTH_BIT] <= bus.reg_wdata[ssp_pkg::TS_TRANSMIT_NINTH_BIT];
            end
            ts_r[ssp_pkg::TS_SHIFT_EMPTY] <= shift_empty;
            if (wr_en) begin
                enables_r <= bus.reg_wdata & 8'h30;
            end
            if (wr_prio) begin
                prio_r <= bus.reg_wdata & 8'h30;
            end
            if (wr_baud) begin
                baud_r <= bus.reg_wdata;
            end
        end
    end

    // flags mirror state: tx empty and rx complete
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flags_r <= 8'h10;
        end else begin
            flags_r[ssp_pkg::TX_FLAG_BIT] <= !tx_hold_full_r && !wr_hold;
            flags_r[ssp_pkg::RX_FLAG_BIT] <= (rx_full_r && !rd_rx) || (rx_done && !rx_full_r);
        end
    end

    // write-only and unused addresses read as zero
    wire [7:0] rd_mux = bus.reg_addr == ssp_pkg::REG_IRQ_FLAGS ? flags_r :
                        bus.reg_addr == ssp_pkg::REG_IRQ_ENABLES ? enables_r :
                        bus.reg_addr == ssp_pkg::REG_IRQ_PRIORITY ? prio_r :
                        bus.reg_addr == ssp_pkg::REG_RX_STATUS ? rs_r :
                        bus.reg_addr == ssp_pkg::REG_TX_STATUS ? ts_r :
                        bus.reg_addr == ssp_pkg::REG_BAUD ? baud_r :
                        bus.reg_addr == ssp_pkg::REG_RX_BUF ? rx_buf_r : 8'h00;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (bus.reg_re) begin
            rdata_r <= rd_mux;
        end
    end
    assign bus.reg_rdata = rdata_r;
    // line released while the shifter idles; the pull-up holds it high
    assign bus.dat_dev_o = tsr_r[0];
    assign bus.dat_dev_oe_n = !(tx_on && tsr_busy_r);
    assign bus.wake_irq = |wake_src;
endmodule : ssp_device

// ===== rtl/ssp_host.sv
`timescale 1ns/1ns
module ssp_host (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // axi4-lite write
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device side
    ssp_if.host bus
);
    logic aw_ok_r, w_ok_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic bvalid_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic [7:0] link_r;
    logic [2:0] busy_r;
    logic [7:0] dev_data_r;
    logic [2:0] div_r;
    logic sck_r;
    // link control: bit0 run clock, bit1 drive data, bit2 data value, bit3 sleep
    wire aw_take = s_axi_awvalid && !aw_ok_r && !bvalid_r;
    wire w_take = s_axi_wvalid && !w_ok_r && !bvalid_r;
    wire wr_go = aw_ok_r && w_ok_r;
    wire wr_cmd = wr_go && awaddr_r == ssp_pkg::AX_CMD;
    wire rd_take = s_axi_arvalid && !rvalid_r && busy_r == 3'h0;
    wire wr_ok = awaddr_r == ssp_pkg::AX_CMD || awaddr_r == ssp_pkg::AX_LINK;

    assign s_axi_awready = aw_take;
    assign s_axi_wready = w_take;
    assign s_axi_arready = rd_take;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            bvalid_r <= 1'b0;
            bresp_r <= ssp_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_ok_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_ok_r <= 1'b1;
                wdata_r <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_ok_r <= 1'b0;
                w_ok_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // command word: bit11 write, bits 10:8 reg, bits 7:0 data; software's job
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            link_r <= 8'h00;
        end else if (wr_go && awaddr_r == ssp_pkg::AX_LINK) begin
            link_r <= wdata_r[7:0];
        end
    end
    assign bus.reg_we = wr_cmd && wdata_r[11];
    assign bus.reg_re = wr_cmd && !wdata_r[11];
    assign bus.reg_addr = wdata_r[10:8];
    assign bus.reg_wdata = wdata_r[7:0];

    // capture the device answer one cycle after a read command
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_r <= 3'h0;
            dev_data_r <= 8'h00;
        end else if (bus.reg_re) begin
            busy_r <= 3'h2;
        end else if (busy_r != 3'h0) begin
            busy_r <= busy_r - 3'h1;
            dev_data_r <= bus.reg_rdata;
        end
    end

    // this end makes the shift clock by division; one bit per period
    always_ff @(posedge core_clk) begin
        if (!rst_n || !link_r[0]) begin
            div_r <= 3'h0;
            sck_r <= 1'b1;
        end else if (div_r == 3'(ssp_pkg::HALF_CYC - 1)) begin
            div_r <= 3'h0;
            sck_r <= !sck_r;
        end else begin
            div_r <= div_r + 3'h1;
        end
    end
    assign bus.sck = sck_r;
    assign bus.dat_host_o = link_r[2];
    assign bus.dat_host_oe_n = !link_r[1];
    assign bus.sleep = link_r[3];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= ssp_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rresp_r <= ssp_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                ssp_pkg::AX_RDATA: rdata_r <= {24'h000000, dev_data_r};
                ssp_pkg::AX_STATUS: rdata_r <= {29'h0, bus.dat, bus.wake_irq, busy_r != 3'h0};
                ssp_pkg::AX_LINK: rdata_r <= {24'h000000, link_r};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= ssp_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule : ssp_host

// ===== tb/ssp_assertions.sv
`timescale 1ns/1ns
module ssp_assertions (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // link
    input wire logic sck,
    input wire logic dat_dev_o,
    input wire logic dat_dev_oe_n,
    input wire logic dat_host_oe_n,
    // register port and wake
    input wire logic reg_we,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic wake_irq
);
    logic [7:0] en_r;
    logic [7:0] rs_r;
    logic [7:0] ts_r;
    wire wr_en = reg_we && reg_addr == ssp_pkg::REG_IRQ_ENABLES;
    wire wr_rs = reg_we && reg_addr == ssp_pkg::REG_RX_STATUS;
    wire wr_ts = reg_we && reg_addr == ssp_pkg::REG_TX_STATUS;
    wire wr_tx = reg_we && reg_addr == ssp_pkg::REG_TX_HOLD;
    wire tx_ok = ts_r[ssp_pkg::TS_TX_EN] && ts_r[ssp_pkg::TS_SYNC] && rs_r[ssp_pkg::RS_PORT_EN];
    // shadow of control bits, written only by the host
    always_ff @(posedge core_clk) begin
        en_r <= !rst_n ? 8'h00 : (wr_en ? reg_wdata : en_r);
        rs_r <= !rst_n ? 8'h00 : (wr_rs ? reg_wdata : rs_r);
        ts_r <= !rst_n ? ssp_pkg::TS_RESET : (wr_ts ? reg_wdata : ts_r);
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_no_contention: assert property (!(!dat_dev_oe_n && !dat_host_oe_n))
        else $error("both ends drive the data line");
    a_bit_held_fall: assert property (!dat_dev_oe_n && $fell(sck) |-> ($stable(dat_dev_o) || dat_dev_oe_n) [*3])
        else $error("data moved near falling shift clock");
    a_bit_moves_rise: assert property (!dat_dev_oe_n && $past(!dat_dev_oe_n) && $changed(dat_dev_o)
        |-> sck || $past(sck) || $past(sck, 2))
        else $error("data moved without a rising shift clock");
    a_wake_enabled: assert property (wake_irq |-> en_r[5] || en_r[4] || $past(en_r[5]) || $past(en_r[4]))
        else $error("wake raised with both enables clear");
    a_wake_masked: assert property (wr_en && reg_wdata[5:4] == 2'b00 |-> ##[1:3] !wake_irq)
        else $error("wake not dropped after masking");
    a_tx_starts: assert property (wr_tx && tx_ok && dat_dev_oe_n |-> ##[1:6] !dat_dev_oe_n)
        else $error("holding write did not start transmission");
    a_port_off_quiet: assert property ((!rs_r[ssp_pkg::RS_PORT_EN]) [*4] |-> dat_dev_oe_n)
        else $error("disabled port drives the data line");
    a_reg_pulse: assert property (reg_we |=> !reg_we)
        else $error("register write strobe longer than one cycle");
    c_tx: cover property (wr_tx ##[1:6] !dat_dev_oe_n);
    c_wake: cover property ($rose(wake_irq));
    c_rx: cover property (!dat_host_oe_n && $fell(sck));
endmodule : ssp_assertions

// ===== tb/test_sync_serial_slave_port.sv
`timescale 1ns/1ns
module test_sync_serial_slave_port;
    logic core_clk;
    logic rst_n;
    logic [11:0] awa;
    logic awv;
    logic [31:0] wd;
    logic wv;
    logic br;
    logic [11:0] ara;
    logic arv;
    logic rr;
    logic awr, wr, bv, arr, rv, pre_sck;
    logic [1:0] bresp, rresp, s;
    logic [31:0] rd, x;
    logic [7:0] b, w0, w1, w2;
    logic got_q[$];
    logic exp_q[$];
    int n_errors, checks_done, k, j;
    ssp_if u_ssp_if ();
    ssp_device u_ssp_device (.core_clk(core_clk), .rst_n(rst_n), .bus(u_ssp_if));
    ssp_host u_ssp_host (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .bus(u_ssp_if));
    ssp_assertions u_ssp_assertions (.core_clk(core_clk), .rst_n(rst_n), .sck(u_ssp_if.sck),
        .dat_dev_o(u_ssp_if.dat_dev_o), .dat_dev_oe_n(u_ssp_if.dat_dev_oe_n),
        .dat_host_oe_n(u_ssp_if.dat_host_oe_n), .reg_we(u_ssp_if.reg_we), .reg_addr(u_ssp_if.reg_addr),
        .reg_wdata(u_ssp_if.reg_wdata), .wake_irq(u_ssp_if.wake_irq));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // the far master samples on the falling shift clock
    always @(posedge core_clk) begin
        if (pre_sck && !u_ssp_if.sck && !u_ssp_if.dat_dev_oe_n) got_q.push_back(u_ssp_if.dat);
        pre_sck <= u_ssp_if.sck;
    end
    task close_out();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk
    task hang();
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 0, 1);
        n_errors++;
        close_out();
    endtask : hang
    task axw(input logic [11:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        @(posedge core_clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(negedge core_clk);
            ah = awv && awr; wh = wv && wr; bh = bv;
            @(posedge core_clk);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
            if (bh) break;
        end
        br <= 1'b0;
        if (k == 100) hang();
    endtask : axw
    task axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, rh;
        @(posedge core_clk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(negedge core_clk);
            ah = arv && arr; rh = rv; d = rd; r = rresp;
            @(posedge core_clk);
            if (ah) arv <= 1'b0;
            if (rh) break;
        end
        rr <= 1'b0;
        if (k == 100) hang();
    endtask : axr
    task dev(input logic wr_n, input logic [2:0] r, input logic [7:0] d);
        int i;
        axw(ssp_pkg::AX_CMD, {20'h0, !wr_n, r, d});
        for (i = 0; i < 20; i++) begin
            axr(ssp_pkg::AX_STATUS, x, s);
            if (x[0] === 1'b0) break;
        end
        if (i == 20) hang();
        if (wr_n) axr(ssp_pkg::AX_RDATA, x, s);
        b = x[7:0];
    endtask : dev
    task tx_words(input logic [7:0] ts, input logic [7:0] a, input logic [7:0] c, input int nw);
        int i;
        dev(0, ssp_pkg::REG_TX_STATUS, ts);
        dev(0, ssp_pkg::REG_TX_HOLD, a);
        if (nw == 2) dev(0, ssp_pkg::REG_TX_HOLD, c);
        dev(1, ssp_pkg::REG_IRQ_FLAGS, 0);
        if (nw == 2) chk(b[4], 1'b0);
        got_q.delete();
        for (i = 0; i < 16; i++) exp_q.push_back(i < 8 ? a[i % 8] : c[i % 8]);
        if (ts[6]) exp_q.insert(8, ts[0]);
        exp_q = exp_q[0:(nw * (ts[6] ? 9 : 8)) - 1];
        axw(ssp_pkg::AX_LINK, 32'h9);
        for (i = 0; i < 900 && got_q.size() < exp_q.size(); i++) @(posedge core_clk);
        if (i == 900) hang();
        foreach (exp_q[j]) chk(got_q[j], exp_q[j]);
        for (i = 0; i < 40; i++) begin
            dev(1, ssp_pkg::REG_TX_STATUS, 0);
            if (b[ssp_pkg::TS_SHIFT_EMPTY] === 1'b1) break;
        end
        if (i == 40) hang();
        chk(b[ssp_pkg::TS_SHIFT_EMPTY], 1'b1);
        axw(ssp_pkg::AX_LINK, 32'h0);
        dev(0, ssp_pkg::REG_IRQ_FLAGS, 8'h00);
        dev(1, ssp_pkg::REG_IRQ_FLAGS, 0);
        chk(b[4], 1'b1);
        chk(u_ssp_if.wake_irq, 1'b1);
        exp_q.delete();
        $display("transmit of %0d words done", nw);
    endtask : tx_words
    initial begin
        rst_n = 1'b0;
        {awa, awv, wd, wv, br, ara, arv, rr, pre_sck} = '0;
        void'($urandom(32'hee9f));
        w0 = $urandom;
        w1 = $urandom;
        w2 = $urandom;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        dev(1, ssp_pkg::REG_IRQ_FLAGS, 0);
        chk(b, 8'h10);
        dev(1, ssp_pkg::REG_TX_STATUS, 0);
        chk(b, ssp_pkg::TS_RESET);
        axr(12'h020, x, s);
        chk(s, ssp_pkg::RESP_SLVERR);
        $display("reset and map test done");
        dev(0, ssp_pkg::REG_RX_STATUS, 8'h80);
        dev(0, ssp_pkg::REG_IRQ_ENABLES, 8'h10);
        tx_words(8'h30, w0, w1, 2);
        tx_words(8'h71, w2, 8'h00, 1);
        dev(0, ssp_pkg::REG_TX_STATUS, 8'h10);
        dev(0, ssp_pkg::REG_IRQ_ENABLES, 8'h20);
        dev(0, ssp_pkg::REG_RX_STATUS, 8'hb0);
        axw(ssp_pkg::AX_LINK, 32'hb);
        for (k = 0; k < 400 && u_ssp_if.wake_irq !== 1'b1; k++) @(posedge core_clk);
        if (k == 400) hang();
        chk(u_ssp_if.wake_irq, 1'b1);
        axw(ssp_pkg::AX_LINK, 32'h0);
        dev(1, ssp_pkg::REG_IRQ_FLAGS, 0);
        chk(b[5], 1'b1);
        dev(1, ssp_pkg::REG_RX_STATUS, 0);
        chk(b & 8'h96, 8'h90);
        dev(1, ssp_pkg::REG_RX_BUF, 0);
        chk(b, 8'h00);
        $display("receive test done");
        dev(0, ssp_pkg::REG_IRQ_ENABLES, 8'h00);
        // restart the receiver so the half word left by the stopped clock is dropped
        dev(0, ssp_pkg::REG_RX_STATUS, 8'h80);
        dev(0, ssp_pkg::REG_RX_STATUS, 8'hb0);
        axw(ssp_pkg::AX_LINK, 32'hf);
        b = 8'h00;
        for (j = 0; j < 60 && b[ssp_pkg::RS_OVERRUN] !== 1'b1; j++) dev(1, ssp_pkg::REG_RX_STATUS, 0);
        if (j == 60) hang();
        chk(b[ssp_pkg::RS_OVERRUN], 1'b1);
        chk(u_ssp_if.wake_irq, 1'b0);
        axw(ssp_pkg::AX_LINK, 32'h0);
        dev(0, ssp_pkg::REG_RX_STATUS, 8'h80);
        dev(1, ssp_pkg::REG_RX_STATUS, 0);
        chk(b & 8'h06, 8'h00);
        dev(1, ssp_pkg::REG_RX_BUF, 0);
        chk(b, 8'hff);
        $display("overrun test done");
        close_out();
    end
endmodule : test_sync_serial_slave_port
